// >>> hdl/ude_pkg.sv
package ude_pkg;
  // Register byte addresses
  localparam logic [7:0] CTL_ADDR   = 8'h40;
  localparam logic [7:0] FLAG_ADDR  = 8'h44;
  localparam logic [7:0] STAT_ADDR  = 8'h48;
  localparam logic [7:0] DADDR_ADDR = 8'h4c;
  localparam logic [15:0] CTL_RST   = 16'h0003;
  // Control bit positions
  localparam int CTL_FRST   = 0;
  localparam int CTL_CLOSE  = 1;
  localparam int CTL_LOW_POWER_ENABLE   = 2;
  localparam int CTL_SPS    = 3;
  localparam int CTL_RESUME_REQUEST  = 4;
  localparam int IE_LSB     = 8;
  // Event flag positions (same in enable and flag registers)
  localparam int EV_FMISS = 8;
  localparam int EV_SOF   = 9;
  localparam int EV_BRST  = 10;
  localparam int EV_SUSP  = 11;
  localparam int EV_WAKE  = 12;
  localparam int EV_ERR   = 13;
  localparam int EV_PMO   = 14;
  localparam int EV_XFER  = 15;
  localparam int DADDR_EN = 7;
  // Timing
  localparam int CLK_HZ        = 20000000;
  localparam int SUSP_IDLE_US  = 3000;
  localparam int SUSP_CYC      = SUSP_IDLE_US * (CLK_HZ / 1000000);
  localparam int RSM_US        = 10000;
  localparam int RSM_CYC       = RSM_US * (CLK_HZ / 1000000);
  // Endpoint direction status codes
  localparam logic [1:0] EP_DIS   = 2'h0;
  localparam logic [1:0] EP_STALL = 2'h1;
  localparam logic [1:0] EP_NAK   = 2'h2;
  localparam logic [1:0] EP_VALID = 2'h3;
  typedef enum logic [1:0] {
    UDE_ACT,
    UDE_SUSP,
    UDE_WAKE
  } ude_pwr_e;
endpackage : ude_pkg

// >>> hdl/ude_ev_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ude_ev_if;
  logic        link_clr;
  logic        bus_act;
  logic        sps;
  logic        idle_tmo;
  logic        resume_det;
  modport ctl (output link_clr, output bus_act, output sps,
               input idle_tmo, input resume_det);
  modport mon (input link_clr, input bus_act, input sps,
               output idle_tmo, output resume_det);
endinterface : ude_ev_if
`default_nettype wire

// >>> hdl/ude_idle_mon.sv
`timescale 1ns/1ns
`default_nettype none
module ude_idle_mon #(
  parameter int unsigned SUSP_CYCLES = ude_pkg::SUSP_CYC
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  ude_ev_if.mon      ev
);
  logic [23:0] idle_cnt_ff;
  logic        hit_ff;
  logic        act_q_ff;
  wire  logic  at_lim = (idle_cnt_ff == 24'(SUSP_CYCLES));

  // Counts quiet bus time; reports once when it reaches the limit
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_cnt_ff <= 24'h0;
      hit_ff      <= 1'b0;
      act_q_ff    <= 1'b0;
    end else begin
      act_q_ff <= ev.bus_act;
      if (ev.link_clr || ev.bus_act || ev.sps) begin
        idle_cnt_ff <= 24'h0;
        hit_ff      <= 1'b0;
      end else if (!at_lim) begin
        idle_cnt_ff <= idle_cnt_ff + 24'h1;
      end else begin
        hit_ff <= 1'b1;
      end
    end
  end
  assign ev.idle_tmo   = at_lim && !hit_ff && !ev.bus_act;
  assign ev.resume_det = ev.sps && ev.bus_act && !act_q_ff;
endmodule : ude_idle_mon
`default_nettype wire

// >>> hdl/ude_top.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module ude_top #(
  parameter int unsigned SUSP_CYCLES = ude_pkg::SUSP_CYC,
  parameter int unsigned RSM_CYCLES  = ude_pkg::RSM_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        bus_reset_i,
  input  wire logic        bus_act_i,
  input  wire logic        sof_i,
  input  wire logic        sof_missed_i,
  input  wire logic        xfer_ok_i,
  input  wire logic        xfer_hp_i,
  input  wire logic        xfer_dir_i,
  input  wire logic [3:0]  xfer_ep_i,
  input  wire logic        err_i,
  input  wire logic        pmo_i,
  input  wire logic        dp_i,
  input  wire logic        dm_i,
  input  wire logic [1:0]  ep_state_i,
  output logic             irq_lp_o,
  output logic             irq_hp_o,
  output logic             irq_wake_o,
  output logic             xcvr_off_o,
  output logic             xcvr_lowpwr_o,
  output logic             core_rst_o,
  output logic             remote_wake_o,
  output logic             module_enable_o,
  output logic [6:0]       dev_addr_o,
  output logic             ep_accept_o
);
  ude_ev_if ev ();
  ude_idle_mon #(.SUSP_CYCLES(SUSP_CYCLES)) u_mon (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ev      (ev)
  );

  logic [15:0] ctl_ff;
  logic [7:0]  flag_ff;
  logic [4:0]  xinfo_ff;
  logic [7:0]  daddr_ff;
  logic [10:0] fcnt_ff;
  logic [1:0]  sofln_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [23:0] rsm_cnt_ff;
  ude_pkg::ude_pwr_e pwr_ff;
  logic [31:0] rdata_ff;

  // Bus reset or forced reset puts the core in its reset state
  wire logic core_rst = bus_reset_i || ctl_ff[ude_pkg::CTL_FRST];
  wire logic shut     = ctl_ff[ude_pkg::CTL_CLOSE];

  // Offset match, shared by the read mux and the write strobes
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] r);
    return a == r;
  endfunction : reg_hit

  // AHB-Lite address/data phase
  wire logic       addr_ok = hsel_i && htrans_i[1] && hready_i;
  wire logic       wr_go   = addr_ok && hwrite_i;
  wire logic [7:0] rd_sel  = haddr_i[7:0];
  wire logic       wr_ctl  = wr_pend_ff &&
                             reg_hit(wr_addr_ff, ude_pkg::CTL_ADDR);
  wire logic       wr_flag = wr_pend_ff &&
                             reg_hit(wr_addr_ff, ude_pkg::FLAG_ADDR);
  wire logic       wr_dadr = wr_pend_ff &&
                             reg_hit(wr_addr_ff, ude_pkg::DADDR_ADDR);
  wire logic [15:0] wd = hwdata_i[15:0];

  // Hardware events in flag order (bit 0 is frame-missing)
  wire logic sps_on    = ctl_ff[ude_pkg::CTL_SPS];
  wire logic [7:0] ev_set = shut ? 8'h00 : {
    xfer_ok_i, pmo_i, err_i, ev.resume_det, ev.idle_tmo,
    bus_reset_i, sof_i && !sps_on,
    sof_missed_i && !sps_on};

  function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                           input logic [7:0] set,
                                           input logic       clr,
                                           input logic [7:0] wv);
    logic [7:0] keep;
    keep = clr ? (cur & wv) : cur;
    // Bit 7 is kept here; flag_ff[7] is cleared by a flag write with bit 15 low
    keep[7] = cur[7] && !(clr && 1'b0);
    return keep | set;
  endfunction : flag_next

  wire logic [7:0] flag_wv  = {1'b1, wd[14:8]};
  wire logic [7:0] nxt_flag = core_rst && !bus_reset_i ? 8'h00 :
                              flag_next(flag_ff, ev_set, wr_flag, flag_wv);
  wire logic xfer_clr = (wr_flag && !wd[ude_pkg::EV_XFER]);

  // Control register next value
  logic [15:0] nxt_ctl;
  always_comb begin
    nxt_ctl = ctl_ff;
    if (wr_ctl) begin
      nxt_ctl = {wd[15:8], 3'h0, wd[4:0]};
    end
    if (ev.resume_det) begin
      nxt_ctl[ude_pkg::CTL_LOW_POWER_ENABLE] = 1'b0;
      nxt_ctl[ude_pkg::CTL_SPS]  = 1'b0;
    end
  end

  wire logic [7:0] irq_vec = flag_ff & ctl_ff[15:8];
  wire logic [15:0] stat = {dp_i, dm_i, 1'b0, sofln_ff, fcnt_ff};
  wire logic [31:0] nxt_rdata =
    reg_hit(rd_sel, ude_pkg::CTL_ADDR)   ? {16'h0, ctl_ff} :
    reg_hit(rd_sel, ude_pkg::FLAG_ADDR)  ? {16'h0, flag_ff, 3'h0, xinfo_ff} :
    reg_hit(rd_sel, ude_pkg::STAT_ADDR)  ? {16'h0, stat} :
    reg_hit(rd_sel, ude_pkg::DADDR_ADDR) ? {24'h0, daddr_ff} : 32'h0;
  wire logic sps_fall = wr_ctl && ctl_ff[ude_pkg::CTL_SPS] &&
                        !wd[ude_pkg::CTL_SPS];
  wire logic rsm_start = (wr_ctl && wd[ude_pkg::CTL_RESUME_REQUEST]) || sps_fall;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h0;
    end else begin
      wr_pend_ff <= wr_go;
      wr_addr_ff <= rd_sel;
      if (addr_ok && !hwrite_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_ff <= ude_pkg::CTL_RST;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_ff  <= 8'h00;
      xinfo_ff <= 5'h00;
    end else begin
      flag_ff[6:0] <= nxt_flag[6:0];
      flag_ff[7]   <= (flag_ff[7] && !xfer_clr) || ev_set[7];
      if (xfer_ok_i) begin
        xinfo_ff <= {xfer_dir_i, xfer_ep_i};
      end
    end
  end

  // Device address and enable; bus reset returns them to zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      daddr_ff <= 8'h00;
      fcnt_ff  <= 11'h000;
      sofln_ff <= 2'h0;
    end else if (core_rst) begin
      daddr_ff <= 8'h00;
      fcnt_ff  <= 11'h000;
      sofln_ff <= 2'h0;
    end else begin
      if (wr_dadr) begin
        daddr_ff <= wd[7:0];
      end
      if (ev_set[1]) begin
        fcnt_ff  <= fcnt_ff + 11'h001;
        sofln_ff <= 2'h0;
      end else if (ev_set[0]) begin
        sofln_ff <= sofln_ff + 2'h1;
      end
    end
  end

  // Power state and remote wakeup signalling
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_ff     <= ude_pkg::UDE_ACT;
      rsm_cnt_ff <= 24'h0;
    end else begin
      unique case (pwr_ff)
        ude_pkg::UDE_ACT: begin
          if (rsm_start && !shut) begin
            pwr_ff     <= ude_pkg::UDE_WAKE;
            rsm_cnt_ff <= 24'(RSM_CYCLES);
          end else if (nxt_ctl[ude_pkg::CTL_SPS]) begin
            pwr_ff <= ude_pkg::UDE_SUSP;
          end
        end
        ude_pkg::UDE_SUSP: begin
          if (ev.resume_det) begin
            pwr_ff <= ude_pkg::UDE_ACT;
          end else if (rsm_start) begin
            pwr_ff     <= ude_pkg::UDE_WAKE;
            rsm_cnt_ff <= 24'(RSM_CYCLES);
          end
        end
        ude_pkg::UDE_WAKE: begin
          if (rsm_cnt_ff <= 24'h1) begin
            pwr_ff <= ude_pkg::UDE_ACT;
          end
          rsm_cnt_ff <= rsm_cnt_ff - 24'h1;
        end
      endcase
    end
  end

  assign ev.link_clr = core_rst || shut;
  assign ev.bus_act  = bus_act_i;
  assign ev.sps      = sps_on;

  // Registered outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_lp_o        <= 1'b0;
      irq_hp_o        <= 1'b0;
      irq_wake_o      <= 1'b0;
      xcvr_off_o      <= 1'b1;
      xcvr_lowpwr_o   <= 1'b0;
      core_rst_o      <= 1'b1;
      remote_wake_o   <= 1'b0;
      module_enable_o <= 1'b0;
      dev_addr_o      <= 7'h00;
      ep_accept_o     <= 1'b0;
    end else begin
      irq_lp_o      <= |irq_vec;
      irq_hp_o      <= irq_vec[7] && xfer_hp_i;
      irq_wake_o    <= irq_vec[4];
      xcvr_off_o    <= shut;
      xcvr_lowpwr_o <= ctl_ff[ude_pkg::CTL_LOW_POWER_ENABLE] && sps_on;
      core_rst_o    <= core_rst;
      remote_wake_o <= (pwr_ff == ude_pkg::UDE_WAKE);
      module_enable_o <= daddr_ff[ude_pkg::DADDR_EN] && !core_rst && !shut;
      dev_addr_o    <= daddr_ff[6:0];
      ep_accept_o   <= (ep_state_i != ude_pkg::EP_DIS);
    end
  end

  assign hrdata_o    = rdata_ff;

  // Slave never stalls and always answers OKAY
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end
endmodule : ude_top
`default_nettype wire

// >>> verification/ude_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ude_top_checker #(
  parameter int unsigned RSM_CYCLES = 20
) (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       bus_reset_i,
  input wire logic       bus_act_i,
  input wire logic [1:0] ep_state_i,
  input wire logic       irq_lp_o,
  input wire logic       irq_hp_o,
  input wire logic       irq_wake_o,
  input wire logic       xcvr_off_o,
  input wire logic       xcvr_lowpwr_o,
  input wire logic       core_rst_o,
  input wire logic       remote_wake_o,
  input wire logic [6:0] dev_addr_o,
  input wire logic       ep_accept_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  int unsigned rw_cnt_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) rw_cnt_ff <= 0;
    else if (remote_wake_o) rw_cnt_ff <= rw_cnt_ff + 1;
    else rw_cnt_ff <= 0;
  end
  AST_BRST_CORE: assert property (bus_reset_i |=> core_rst_o)
    else $error("core reset not raised by bus reset");
  AST_BRST_ADDR: assert property (
    bus_reset_i |-> ##[1:2] dev_addr_o == 7'h00)
    else $error("address not cleared by bus reset");
  AST_RST_VAL: assert property (
    !$past(rst_n_i) |-> xcvr_off_o && core_rst_o)
    else $error("shutdown or forced reset low after reset");
  AST_EP_ACCEPT: assert property (
    1 |=> ep_accept_o == ($past(ep_state_i) != 2'h0))
    else $error("endpoint accept does not follow status code");
  AST_LOWPWR_EXIT: assert property (
    xcvr_lowpwr_o && $rose(bus_act_i) |-> ##[1:4] !xcvr_lowpwr_o)
    else $error("low power kept after resume");
  AST_RWAKE_LEN: assert property ($fell(remote_wake_o) |->
    rw_cnt_ff + 1 >= RSM_CYCLES && rw_cnt_ff <= RSM_CYCLES + 1)
    else $error("remote wake length wrong");
  AST_WAKE_LP: assert property (irq_wake_o |-> irq_lp_o)
    else $error("wake request without low priority request");
  AST_HP_LP: assert property (irq_hp_o |-> irq_lp_o)
    else $error("high priority request without low priority request");
  cover property ($fell(remote_wake_o));
  cover property ($rose(irq_wake_o));
  cover property (irq_hp_o);
endmodule : ude_top_checker
`default_nettype wire

// >>> verification/ude_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ude_host_model (
  input  wire logic mclk_i,
  output logic      bus_reset_o,
  output logic      bus_act_o,
  output logic      sof_o,
  output logic      dp_o,
  output logic      dm_o
);
  // Idle J state with the device pull-up on the plus line
  initial {bus_reset_o, bus_act_o, sof_o, dp_o, dm_o} = 5'b00010;
  task automatic drv(input logic [4:0] v);
    {bus_reset_o, bus_act_o, sof_o, dp_o, dm_o} <= v;
  endtask : drv
  task automatic bus_reset();
    drv(5'b11000);
    repeat (4) @(posedge mclk_i);
    drv(5'b00010);
  endtask : bus_reset
  task automatic resume();
    drv(5'b01001);
    repeat (6) @(posedge mclk_i);
    drv(5'b00010);
  endtask : resume
  task automatic sof();
    drv(5'b01110);
    @(posedge mclk_i);
    drv(5'b00010);
  endtask : sof
endmodule : ude_host_model
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  localparam int unsigned SUSP = 50;
  localparam int unsigned RSM  = 20;
  logic        mclk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, q, rn;
  logic [1:0]  htrans_i, ep_state_i;
  logic [3:0]  ev, xfer_ep_i;
  logic        bus_reset_i, bus_act_i, sof_i, dp_i, dm_i, xfer_hp_i;
  logic        xfer_dir_i, irq_lp_o, irq_hp_o, irq_wake_o, xcvr_off_o;
  logic        xcvr_lowpwr_o, core_rst_o, remote_wake_o, module_enable_o;
  logic        ep_accept_o;
  logic [6:0]  dev_addr_o;
  int          checks, fails, seed, b;
  int          bits[4] = '{ude_pkg::EV_XFER, ude_pkg::EV_ERR,
                           ude_pkg::EV_PMO, ude_pkg::EV_FMISS};
  ude_top #(.SUSP_CYCLES(SUSP), .RSM_CYCLES(RSM)) u_dut (
    .mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o, .bus_reset_i, .bus_act_i, .sof_i,
    .sof_missed_i(ev[3]), .xfer_ok_i(ev[0]), .xfer_hp_i, .xfer_dir_i,
    .xfer_ep_i, .err_i(ev[1]), .pmo_i(ev[2]), .dp_i, .dm_i, .ep_state_i,
    .irq_lp_o, .irq_hp_o, .irq_wake_o, .xcvr_off_o, .xcvr_lowpwr_o,
    .core_rst_o, .remote_wake_o, .module_enable_o, .dev_addr_o,
    .ep_accept_o);
  ude_host_model u_host (.mclk_i, .bus_reset_o(bus_reset_i),
    .bus_act_o(bus_act_i), .sof_o(sof_i), .dp_o(dp_i), .dm_o(dm_i));
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      results();
    end
  endtask : hwait
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i  <= {24'h0, a};
    hwait();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    hwait();
    r = hrdata_o;
    `CHK("hresp", 1'b0, hresp_o)
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic settle();
    repeat (2) @(negedge mclk_i);
  endtask : settle
  task automatic rw_wait(input logic v, input int lim);
    int n;
    n = 0;
    while (remote_wake_o !== v && n < lim) begin
      @(negedge mclk_i);
      n++;
    end
    `CHK("rwake", v, remote_wake_o)
  endtask : rw_wait
  function automatic logic [31:0] ctl_rb(input logic [15:0] w);
    return {16'h0, w & 16'hff1f};
  endfunction : ctl_rb
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    results();
  end
  initial begin
    seed = 32'hc26519c4;
    {rst_n_i, hsel_i, hwrite_i, xfer_hp_i, xfer_dir_i} = 5'h0;
    {haddr_i, hwdata_i, htrans_i, ep_state_i, ev, xfer_ep_i} = '0;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, ude_pkg::CTL_ADDR, 32'h0, q);
    `CHK("ctl_rst", 32'h3, q)
    wr(ude_pkg::CTL_ADDR, 32'h1);
    settle();
    `CHK("close", 1'b0, xcvr_off_o)
    `CHK("frst", 1'b1, core_rst_o)
    for (int i = 0; i < 3; i++) begin
      rn = $random(seed);
      wr(ude_pkg::CTL_ADDR, {16'h0, rn[15:5], 5'h0});
      bus(1'b0, ude_pkg::CTL_ADDR, 32'h0, q);
      `CHK("ctl", ctl_rb({rn[15:5], 5'h0}), q)
    end
    wr(ude_pkg::CTL_ADDR, 32'h0);
    wr(ude_pkg::FLAG_ADDR, 32'h0);
    settle();
    `CHK("frst_off", 1'b0, core_rst_o)
    for (int i = 0; i < 4; i++) begin
      rn = $random(seed);
      b  = bits[i];
      @(posedge mclk_i);
      {xfer_hp_i, xfer_dir_i, xfer_ep_i} <= rn[5:0];
      ev <= 4'h1 << i;
      @(posedge mclk_i);
      ev <= 4'h0;
      wr(ude_pkg::FLAG_ADDR, 32'hffff);
      bus(1'b0, ude_pkg::FLAG_ADDR, 32'h0, q);
      `CHK("flag", 1'b1, q[b])
      if (i == 0) `CHK("ep", rn[4:0], q[4:0])
      `CHK("masked", 1'b0, irq_lp_o)
      wr(ude_pkg::CTL_ADDR, 32'h1 << b);
      settle();
      `CHK("lp", 1'b1, irq_lp_o)
      `CHK("hp", 1'(i == 0 && rn[5]), irq_hp_o)
      wr(ude_pkg::FLAG_ADDR, 32'h0);
      settle();
      `CHK("clr", 1'b0, irq_lp_o)
    end
    rn = $random(seed);
    wr(ude_pkg::DADDR_ADDR, {24'h0, 1'b1, rn[6:0]});
    settle();
    `CHK("addr", rn[6:0], dev_addr_o)
    `CHK("men", 1'b1, module_enable_o)
    @(posedge mclk_i);
    u_host.bus_reset();
    settle();
    `CHK("addr_rst", 7'h0, dev_addr_o)
    bus(1'b0, ude_pkg::FLAG_ADDR, 32'h0, q);
    `CHK("brst", 1'b1, q[ude_pkg::EV_BRST])
    wr(ude_pkg::FLAG_ADDR, 32'h0);
    @(posedge mclk_i);
    u_host.sof();
    repeat (SUSP - 20) @(posedge mclk_i);
    bus(1'b0, ude_pkg::FLAG_ADDR, 32'h0, q);
    `CHK("early", 1'b0, q[ude_pkg::EV_SUSP])
    repeat (20) @(posedge mclk_i);
    bus(1'b0, ude_pkg::FLAG_ADDR, 32'h0, q);
    `CHK("susp", 1'b1, q[ude_pkg::EV_SUSP])
    wr(ude_pkg::CTL_ADDR, 32'h100c);
    settle();
    `CHK("lowpwr", 1'b1, xcvr_lowpwr_o)
    @(posedge mclk_i);
    ev <= 4'h8;
    @(posedge mclk_i);
    ev <= 4'h0;
    bus(1'b0, ude_pkg::FLAG_ADDR, 32'h0, q);
    `CHK("nomiss", 1'b0, q[ude_pkg::EV_FMISS])
    bus(1'b0, ude_pkg::STAT_ADDR, 32'h0, q);
    `CHK("stat", 32'h8001, q)
    @(posedge mclk_i);
    u_host.resume();
    settle();
    `CHK("wake", 1'b1, irq_wake_o)
    `CHK("lp_exit", 1'b0, xcvr_lowpwr_o)
    bus(1'b0, ude_pkg::CTL_ADDR, 32'h0, q);
    `CHK("ctl_exit", 32'h1000, q)
    wr(ude_pkg::FLAG_ADDR, 32'h0);
    for (int j = 0; j < 2; j++) begin
      wr(ude_pkg::CTL_ADDR, j == 0 ? 32'h8 : 32'h10);
      if (j == 0) wr(ude_pkg::CTL_ADDR, 32'h0);
      rw_wait(1'b1, 8);
      rw_wait(1'b0, RSM + 8);
      wr(ude_pkg::CTL_ADDR, 32'h0);
      settle();
      `CHK("rw_idle", 1'b0, remote_wake_o)
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i);
      ep_state_i <= 2'(k);
      settle();
      `CHK("accept", 1'(k != 0), ep_accept_o)
    end
    results();
  end
endmodule : testbench
bind ude_top ude_top_checker #(.RSM_CYCLES(RSM_CYCLES)) u_chk (
  .mclk_i, .rst_n_i, .bus_reset_i, .bus_act_i, .ep_state_i, .irq_lp_o,
  .irq_hp_o, .irq_wake_o, .xcvr_off_o, .xcvr_lowpwr_o, .core_rst_o,
  .remote_wake_o, .dev_addr_o, .ep_accept_o);
`default_nettype wire
